// ===== rtl/iea_regs.svh
// Register map, field positions and timing constants of the indirect access block
`ifndef IEA_REGS_SVH
`define IEA_REGS_SVH
// Register indices; byte address is four times the index
`define IEA_IDX_STAT1 6'h12
`define IEA_IDX_STAT2 6'h13
`define IEA_IDX_STAT3 6'h14
`define IEA_IDX_EN1 6'h15
`define IEA_IDX_EN2 6'h16
`define IEA_IDX_EN3 6'h17
`define IEA_IDX_DLO 6'h1c
`define IEA_IDX_DHI 6'h1d
`define IEA_IDX_ADDR 6'h1e
`define IEA_IDX_ASTAT 6'h1f
// Field positions and widths
`define IEA_IND_BIT 1
`define IEA_IAS_BIT 0
`define IEA_W1 6
`define IEA_W2 8
// Reset and fill values
`define IEA_ZERO_BYTE 8'h00
`define IEA_ZERO_PAD 24'h000000
// Bus responses
`define IEA_RESP_OKAY 2'b00
`define IEA_RESP_SLVERR 2'b10
// Indirect update period and its cycle count
`define IEA_UPDATE_NS 62500
`define IEA_CLK_NS 40
`define IEA_TICK_CYC (`IEA_UPDATE_NS / `IEA_CLK_NS)
`define IEA_TICK_LAST 11'((`IEA_TICK_CYC) - 1)
`endif

// ===== rtl/iea_pkg.sv
// Types of the indirect access register block
package iea_pkg;
  typedef enum logic [1:0] {IEA_IDLE, IEA_RD, IEA_WR} iea_op_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [5:0] waddr;
    logic [7:0] wdat;
    logic wstb;
    logic [5:0] stat1;
    logic [7:0] stat2;
    logic stat3;
    logic [5:0] en1;
    logic [7:0] en2;
    logic en3;
    logic [15:0] data;
    logic [7:0] addr;
    logic data_wr;
    iea_op_t op;
    logic [10:0] tick_cnt;
    logic irq;
    logic [255:0][15:0] mem;
  } iea_state_t;
endpackage

// ===== rtl/iea_top.sv
// Interrupt enable registers and indirect register access window on AXI4-Lite
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "iea_regs.svh"

// Notes on behaviour
// (R1) Completed indirect request sets the serviced pending flag.
// (R2) Writing one clears the serviced flag; zero leaves it; read shows it.
// (R3) Enable three bit one gates the serviced interrupt; read and write.
// (R4) Enable one holds six oscillator and ringing timer mask bits.
// (R5) Enable two holds eight power alarm, loop closure and ring trip masks.
// (R6) Data then address written: data stored into addressed cell at update.
// (R7) Address only written: addressed cell loaded into data at update.
// (R8) Transfers happen only at the 16 kHz update instants.
// (R9) Sixteen-bit data word split into low and high byte registers.
// (R10) Address status bit zero reads one while an access is pending.
// (R11) Status one and two flags clear on writing one; pair with enables.
// (R12) Interrupt raised while any pending flag has its enable set.
module iea_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [5:0] osc_ring_event,
  input wire logic [7:0] power_loop_event,
  output logic irq
);

  iea_pkg::iea_state_t r_reg;
  iea_pkg::iea_state_t r_next;

  // Register index is mapped or not
  function automatic logic idx_hit(input logic [5:0] idx);
    case (idx)
      `IEA_IDX_STAT1, `IEA_IDX_STAT2, `IEA_IDX_STAT3, `IEA_IDX_EN1, `IEA_IDX_EN2,
      `IEA_IDX_EN3, `IEA_IDX_DLO, `IEA_IDX_DHI, `IEA_IDX_ADDR, `IEA_IDX_ASTAT: idx_hit = 1'b1;
      default: idx_hit = 1'b0;
    endcase
  endfunction

  // Read value of one register, reserved bits zero
  function automatic logic [7:0] rd_byte(input iea_pkg::iea_state_t s, input logic [5:0] idx);
    logic [7:0] v;
    v = `IEA_ZERO_BYTE;
    case (idx)
      `IEA_IDX_STAT1: v[`IEA_W1-1:0] = s.stat1;
      `IEA_IDX_STAT2: v = s.stat2;
      `IEA_IDX_STAT3: v[`IEA_IND_BIT] = s.stat3; // [R2]
      `IEA_IDX_EN1: v[`IEA_W1-1:0] = s.en1;
      `IEA_IDX_EN2: v = s.en2;
      `IEA_IDX_EN3: v[`IEA_IND_BIT] = s.en3;
      `IEA_IDX_DLO: v = s.data[7:0];
      `IEA_IDX_DHI: v = s.data[15:8];
      `IEA_IDX_ADDR: v = s.addr;
      `IEA_IDX_ASTAT: v[`IEA_IAS_BIT] = (s.op != iea_pkg::IEA_IDLE); // [R10]
      default: v = `IEA_ZERO_BYTE;
    endcase
    rd_byte = v;
  endfunction

  // Next state: bus slave, indirect engine, interrupt flags
  always_comb begin
    logic [5:0] clr1;
    logic [7:0] clr2;
    logic clr3;
    logic tick;
    logic do_wr;
    clr1 = '0;
    clr2 = '0;
    clr3 = 1'b0;
    r_next = r_reg;
    // Update instant generator
    tick = (r_reg.tick_cnt == `IEA_TICK_LAST);
    r_next.tick_cnt = tick ? 11'h000 : r_reg.tick_cnt + 11'h001;
    // Indirect transfer only at the update instant
    if (tick && r_reg.op != iea_pkg::IEA_IDLE) begin // [R8]
      if (r_reg.op == iea_pkg::IEA_WR) begin
        r_next.mem[r_reg.addr] = r_reg.data; // [R6]
      end else begin
        r_next.data = r_reg.mem[r_reg.addr]; // [R7]
      end
      r_next.op = iea_pkg::IEA_IDLE;
    end
    // Write address and data are taken in either order
    if (awvalid && r_reg.awready) begin
      r_next.aw_got = 1'b1;
      r_next.waddr = awaddr[7:2];
    end
    if (wvalid && r_reg.wready) begin
      r_next.w_got = 1'b1;
      r_next.wdat = wdata[7:0];
      r_next.wstb = wstrb[0];
    end
    do_wr = r_reg.aw_got && r_reg.w_got;
    if (do_wr) begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = idx_hit(r_reg.waddr) ? `IEA_RESP_OKAY : `IEA_RESP_SLVERR;
      if (r_reg.wstb) begin
        case (r_reg.waddr)
          `IEA_IDX_STAT1: clr1 = r_reg.wdat[`IEA_W1-1:0]; // [R11]
          `IEA_IDX_STAT2: clr2 = r_reg.wdat; // [R11]
          `IEA_IDX_STAT3: clr3 = r_reg.wdat[`IEA_IND_BIT]; // [R2]
          `IEA_IDX_EN1: r_next.en1 = r_reg.wdat[`IEA_W1-1:0]; // [R4]
          `IEA_IDX_EN2: r_next.en2 = r_reg.wdat; // [R5]
          `IEA_IDX_EN3: r_next.en3 = r_reg.wdat[`IEA_IND_BIT]; // [R3]
          `IEA_IDX_DLO: begin
            r_next.data[7:0] = r_reg.wdat; // [R9]
            r_next.data_wr = 1'b1;
          end
          `IEA_IDX_DHI: begin
            r_next.data[15:8] = r_reg.wdat; // [R9]
            r_next.data_wr = 1'b1;
          end
          `IEA_IDX_ADDR: begin
            r_next.addr = r_reg.wdat;
            r_next.op = r_reg.data_wr ? iea_pkg::IEA_WR : iea_pkg::IEA_RD; // [R6] [R7]
            r_next.data_wr = 1'b0;
          end
          default: r_next.data_wr = r_reg.data_wr;
        endcase
      end
    end
    if (r_reg.bvalid && bready) begin
      r_next.bvalid = 1'b0;
    end
    r_next.awready = !r_next.aw_got && !r_next.bvalid;
    r_next.wready = !r_next.w_got && !r_next.bvalid;
    // Read channel, one outstanding read
    if (arvalid && r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.rdata = {`IEA_ZERO_PAD, rd_byte(r_reg, araddr[7:2])};
      r_next.rresp = idx_hit(araddr[7:2]) ? `IEA_RESP_OKAY : `IEA_RESP_SLVERR;
    end else if (r_reg.rvalid && rready) begin
      r_next.rvalid = 1'b0;
    end
    r_next.arready = !r_next.rvalid;
    // Sticky flags, set wins over clear
    r_next.stat1 = (r_reg.stat1 & ~clr1) | osc_ring_event; // [R11]
    r_next.stat2 = (r_reg.stat2 & ~clr2) | power_loop_event; // [R11]
    r_next.stat3 = (r_reg.stat3 & ~clr3) | (tick && r_reg.op != iea_pkg::IEA_IDLE); // [R1]
    r_next.irq = |(r_next.stat1 & r_next.en1) | |(r_next.stat2 & r_next.en2)
      | (r_next.stat3 & r_next.en3); // [R12]
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r_reg <= iea_pkg::iea_state_t'('0);
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign awready = r_reg.awready;
  assign wready = r_reg.wready;
  assign bvalid = r_reg.bvalid;
  assign bresp = r_reg.bresp;
  assign arready = r_reg.arready;
  assign rvalid = r_reg.rvalid;
  assign rresp = r_reg.rresp;
  assign rdata = r_reg.rdata;
  assign irq = r_reg.irq;

  // Checks
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic upd;
  assign upd = (r_reg.tick_cnt == `IEA_TICK_LAST);

  // Cycles a request has been waiting; restarts when a new address write replaces it
  logic [11:0] pend_cnt;
  always_ff @(posedge mclk) begin
    if (!rst_n || r_reg.op == iea_pkg::IEA_IDLE
      || (r_reg.aw_got && r_reg.w_got && r_reg.wstb && r_reg.waddr == `IEA_IDX_ADDR)) begin
      pend_cnt <= 12'h000;
    end else begin
      pend_cnt <= pend_cnt + 12'h001;
    end
  end

  serviced_flag_set_a: assert property (upd && r_reg.op != iea_pkg::IEA_IDLE |=> r_reg.stat3) // [R1]
    else $error("serviced flag not set on completion");
  serviced_w1c_a: assert property (r_reg.aw_got && r_reg.w_got && r_reg.wstb
    && r_reg.waddr == `IEA_IDX_STAT3 && r_reg.wdat[`IEA_IND_BIT] && !upd |=> !r_reg.stat3) // [R2]
    else $error("serviced flag not cleared by write of one");
  enable_three_a: assert property (r_reg.aw_got && r_reg.w_got && r_reg.wstb
    && r_reg.waddr == `IEA_IDX_EN3 |=> r_reg.en3 == $past(r_reg.wdat[`IEA_IND_BIT])) // [R3]
    else $error("enable three not written");
  indirect_store_a: assert property (upd && r_reg.op == iea_pkg::IEA_WR
    |=> r_reg.mem[$past(r_reg.addr)] == $past(r_reg.data)) // [R6]
    else $error("indirect write not stored");
  indirect_load_a: assert property (upd && r_reg.op == iea_pkg::IEA_RD && !(r_reg.aw_got && r_reg.w_got)
    |=> r_reg.data == $past(r_reg.mem[r_reg.addr])) // [R7]
    else $error("indirect read not loaded");
  update_bound_a: assert property (pend_cnt < 12'(`IEA_TICK_CYC)) // [R8]
    else $error("indirect request not serviced in one update period");
  no_early_service_a: assert property (r_reg.op != iea_pkg::IEA_IDLE && !upd
    && !(r_reg.aw_got && r_reg.w_got) |=> r_reg.op != iea_pkg::IEA_IDLE) // [R8]
    else $error("indirect request serviced off the update instant");
  access_status_a: assert property (arvalid && arready && araddr[7:2] == `IEA_IDX_ASTAT
    |=> rvalid && rdata[`IEA_IAS_BIT] == ($past(r_reg.op) != iea_pkg::IEA_IDLE)) // [R10]
    else $error("address status bit wrong");
  irq_follows_a: assert property (osc_ring_event[0] && r_reg.en1[0] && !(r_reg.aw_got && r_reg.w_got)
    |=> irq) // [R12]
    else $error("unmasked event did not raise interrupt");
  resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

  indirect_write_c: cover property (upd && r_reg.op == iea_pkg::IEA_WR);
  indirect_read_c: cover property (upd && r_reg.op == iea_pkg::IEA_RD);
  irq_raise_c: cover property ($rose(irq));
  slverr_c: cover property (rvalid && rresp == `IEA_RESP_SLVERR);

endmodule
`default_nettype wire

// ===== tb/irq_enable_indirect_access_bench.sv
// Self-checking bench of the interrupt enable and indirect access registers
`timescale 1ns/1ps
`default_nettype none
`include "iea_regs.svh"
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("wrong value at %0t: %s", $time, m); end end

module irq_enable_indirect_access_bench;
  logic mclk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [7:0] awaddr, araddr, e1, e2, v1, v2, lo, hi, ia, rd;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [5:0] osc_ring_event;
  logic [7:0] power_loop_event;
  int bad_count = 0;
  int n_checks = 0;
  int seed, t0, t1;
  int cyc = 0;

  iea_top iea_top_inst (.mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .osc_ring_event(osc_ring_event), .power_loop_event(power_loop_event),
    .irq(irq));

  // Clock of 40 ns and a cycle count
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  // Verdict and end of run
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Bus write of one register word
  task wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er);
    awaddr <= {i, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    `CHK(bresp, er, "write response")
  endtask

  // Bus read of one register word
  task rdr(input logic [5:0] i, output logic [7:0] d);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata[7:0];
    rs = rresp;
  endtask

  // Read and compare
  task cr(input logic [5:0] i, input logic [7:0] e);
    rdr(i, rd);
    `CHK(rd, e, "register read")
  endtask

  // Poll until no indirect access is pending
  task wait_done;
    int k;
    k = 0;
    do begin
      rdr(`IEA_IDX_ASTAT, rd);
      k++;
    end while (rd[0] === 1'b1 && k < 1000);
    `CHK(rd[0], 1'b0, "access still pending")
  endtask

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    osc_ring_event = 6'h00;
    power_loop_event = 8'h00;
    seed = 6;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    cr(`IEA_IDX_DLO, 8'h00);
    cr(`IEA_IDX_STAT3, 8'h00);
    cr(`IEA_IDX_ASTAT, 8'h00);
    // Enable one and two with random values, enable three with all ones; reserved bits read zero
    repeat (3) begin
      e1 = 8'($random(seed));
      e2 = 8'($random(seed));
      wr(`IEA_IDX_EN1, e1, `IEA_RESP_OKAY);
      wr(`IEA_IDX_EN2, e2, `IEA_RESP_OKAY);
      wr(`IEA_IDX_EN3, 8'hff, `IEA_RESP_OKAY);
      cr(`IEA_IDX_EN1, e1 & 8'h3f);
      cr(`IEA_IDX_EN2, e2);
      cr(`IEA_IDX_EN3, 8'h02);
    end
    // Unmapped place is refused
    wr(6'h00, 8'hff, `IEA_RESP_SLVERR);
    rdr(6'h00, rd);
    `CHK(rs, `IEA_RESP_SLVERR, "read response")
    // Events set sticky flags, cleared by writing ones
    v1 = 8'($random(seed)) & 8'h3f;
    v2 = 8'($random(seed)) | 8'h01;
    osc_ring_event <= v1[5:0];
    power_loop_event <= v2;
    @(posedge mclk);
    osc_ring_event <= 6'h00;
    power_loop_event <= 8'h00;
    cr(`IEA_IDX_STAT1, v1);
    cr(`IEA_IDX_STAT2, v2);
    `CHK(irq, |((v1 & e1) | (v2 & e2)), "irq level")
    wr(`IEA_IDX_STAT2, v2 & 8'h55, `IEA_RESP_OKAY);
    cr(`IEA_IDX_STAT2, v2 & 8'haa);
    wr(`IEA_IDX_STAT1, 8'hff, `IEA_RESP_OKAY);
    wr(`IEA_IDX_STAT2, 8'hff, `IEA_RESP_OKAY);
    cr(`IEA_IDX_STAT1, 8'h00);
    `CHK(irq, 1'b0, "irq after clear")
    // Indirect read of an untouched cell aligns to an update
    lo = 8'($random(seed));
    hi = 8'($random(seed));
    ia = 8'($random(seed));
    wr(`IEA_IDX_ADDR, ia ^ 8'h01, `IEA_RESP_OKAY);
    wait_done;
    t0 = cyc;
    cr(`IEA_IDX_DLO, 8'h00);
    // Indirect write, serviced at the next update
    wr(`IEA_IDX_DLO, lo, `IEA_RESP_OKAY);
    wr(`IEA_IDX_DHI, hi, `IEA_RESP_OKAY);
    wr(`IEA_IDX_ADDR, ia, `IEA_RESP_OKAY);
    cr(`IEA_IDX_ASTAT, 8'h01);
    wait_done;
    t1 = cyc;
    `CHK((t1 - t0 >= `IEA_TICK_CYC - 8) && (t1 - t0 <= `IEA_TICK_CYC + 8), 1'b1, "update spacing")
    cr(`IEA_IDX_STAT3, 8'h02);
    `CHK(irq, 1'b1, "serviced irq")
    wr(`IEA_IDX_STAT3, 8'h00, `IEA_RESP_OKAY);
    cr(`IEA_IDX_STAT3, 8'h02);
    wr(`IEA_IDX_STAT3, 8'h02, `IEA_RESP_OKAY);
    cr(`IEA_IDX_STAT3, 8'h00);
    `CHK(irq, 1'b0, "irq after serviced clear")
    // Masked completion, then read back the written cell
    wr(`IEA_IDX_EN3, 8'h00, `IEA_RESP_OKAY);
    wr(`IEA_IDX_ADDR, ia ^ 8'h01, `IEA_RESP_OKAY);
    wait_done;
    cr(`IEA_IDX_DHI, 8'h00);
    cr(`IEA_IDX_STAT3, 8'h02);
    `CHK(irq, 1'b0, "masked irq")
    wr(`IEA_IDX_ADDR, ia, `IEA_RESP_OKAY);
    wait_done;
    cr(`IEA_IDX_DLO, lo);
    cr(`IEA_IDX_DHI, hi);
    report_and_stop;
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
